// ==== hw/flip_pkg.sv ====
// Shared constants and carrier types of the four-level interrupt controller
package flip_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_TIMER_CTRL = 8'h88;
  localparam logic [7:0] IDX_AUX_CTRL   = 8'h8E;
  localparam logic [7:0] IDX_PRIO_HIGH  = 8'hB7;
  localparam logic [7:0] IDX_PRIO_LOW   = 8'hB8;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hE8;
  // Reset values
  localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
  localparam logic [7:0] RST_AUX_CTRL   = 8'h00;
  localparam logic [7:0] RST_PRIO       = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  // Timer control fields
  localparam int EXT0_TYPE  = 0;
  localparam int EXT0_FLAG  = 1;
  localparam int EXT1_TYPE  = 2;
  localparam int EXT1_FLAG  = 3;
  localparam int TMR0_RUN   = 4;
  localparam int TMR0_FLAG  = 5;
  localparam int TMR1_RUN   = 6;
  localparam int TMR1_FLAG  = 7;
  // Enable register and auxiliary fields
  localparam int GLOBAL_EN  = 7;
  localparam int LOWVOLT_EN = 2;
  localparam int SPI_EN     = 3;
  localparam int ADC_EN     = 4;
  localparam int AUX_MODE   = 5;
  // Sources in polling order
  localparam int NUM_SRC    = 7;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_TMR0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_TMR1 = 3'h3;
  // Vector addresses: base plus step times source
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // Status presented by the core every cycle
  typedef struct packed {
    logic lastCycle;     // Final cycle of current instruction
    logic isReturn;      // Current instruction returns from handler
    logic writesIrqRegs; // Current instruction writes enable or priority
  } flip_core_t;

  // Vector call request to the core
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } flip_vec_t;
endpackage

// ==== hw/flip_irq_ctrl.sv ====
// Four-level priority interrupt controller with a Wishbone register slave
// Behaviour
// RULE1 - Priority level from high and low bits
// RULE2 - Lower level never preempts running handler
// RULE3 - Higher level wins among pending requests
// RULE4 - Same level resolved by fixed polling order
// RULE5 - Sample flags, poll next cycle, then call
// RULE6 - No call while equal/higher level active
// RULE7 - Call only on instruction final cycle
// RULE8 - Return or priority write delays one instruction
// RULE9 - Type bit: 0 low level, 1 falling edge
// RULE10 - External flags set by hardware, edge-cleared on entry
// RULE11 - Global enable gates all sources
// RULE12 - Enable bits 6..0 per source
// RULE13 - ADC, SPI, low-voltage sub-enables in auxiliary
// RULE14 - Low priority bits 6..0 per source
// RULE15 - High priority bits form upper pair bit
// RULE16 - Software writes zero to reserved top bit
// RULE17 - Timer flags cleared on vectoring
// RULE18 - Serial request is receive OR transmit
// RULE19 - SPI/ADC group OR of enabled flags
// RULE20 - PCA/low-voltage group OR of enabled flags
// RULE21 - Polling order and per-source vector address
// RULE22 - Track active levels, release highest on return
// RULE23 - Core gives final-cycle, return, accepts vector
module flip_irq_ctrl (
  input  wire logic                clk,          // System clock, 40 MHz
  input  wire logic                reset_n,      // Synchronous reset, active low
  input  wire logic                wb_cyc_i,     // Wishbone cycle
  input  wire logic                wb_stb_i,     // Wishbone strobe
  input  wire logic                wb_we_i,      // Wishbone write
  input  wire logic [9:0]          wb_adr_i,     // Wishbone byte address
  input  wire logic [3:0]          wb_sel_i,     // Wishbone byte enables
  input  wire logic [31:0]         wb_dat_i,     // Wishbone write data
  output logic [31:0]              wb_dat_o,     // Wishbone read data
  output logic                     wb_ack_o,     // Wishbone acknowledge
  input  wire logic                extInputZero, // External pin 0, async
  input  wire logic                extInputOne,  // External pin 1, async
  input  wire logic                timer0Ovf,    // Timer 0 rollover pulse
  input  wire logic                timer1Ovf,    // Timer 1 rollover pulse
  input  wire logic                uartRxFlag,   // Serial receive flag
  input  wire logic                uartTxFlag,   // Serial transmit flag
  input  wire logic                spiDoneFlag,  // SPI transfer done flag
  input  wire logic                spiWcolFlag,  // SPI write collision flag
  input  wire logic                adcDoneFlag,  // ADC conversion done flag
  input  wire logic                pcaOvfFlag,   // PCA counter overflow flag
  input  wire logic                pcaOvfEn,     // PCA counter overflow enable
  input  wire logic [3:0]          pcaMatchFlags, // PCA module flags
  input  wire logic [3:0]          pcaMatchEn,   // PCA module enables
  input  wire logic                lowVoltFlag,  // Low-voltage flag
  input  wire flip_pkg::flip_core_t coreStatus,  // Core instruction status
  output flip_pkg::flip_vec_t      vecCall,      // Vector call to core
  output logic                     timer0Run,    // Timer 0 run bit
  output logic                     timer1Run,    // Timer 1 run bit
  output logic [2:0]               auxMode       // Auxiliary mode bits 7..5
);
  // Register state
  logic [7:0] tconQ, tconD, auxQ, iphQ, iplQ, ieQ;
  logic       ackQ, holdOffQ, vecReqQ;
  logic [31:0] rdatQ;
  logic [15:0] vecAddrQ;
  logic [2:0]  vecSrcQ;
  logic [1:0]  vecLvQ;
  logic [3:0]  activeQ, activeD;
  logic [6:0]  sampleQ;
  logic [1:0]  extMetaQ, extSyncQ, extPrevQ;

  // Bus decode
  wire logic access   = wb_cyc_i & wb_stb_i;
  wire logic wrStrobe = access & wb_we_i & ackQ & wb_sel_i[0];
  wire logic [7:0] idx = wb_adr_i[9:2];
  wire logic selTcon = idx == flip_pkg::IDX_TIMER_CTRL;
  wire logic selAux  = idx == flip_pkg::IDX_AUX_CTRL;
  wire logic selIph  = idx == flip_pkg::IDX_PRIO_HIGH;
  wire logic selIpl  = idx == flip_pkg::IDX_PRIO_LOW;
  wire logic selIe   = idx == flip_pkg::IDX_IRQ_ENABLE;
  wire logic wrPrioEn = wrStrobe & (selIph | selIpl | selIe);

  // Read mux; reserved bits and unmapped addresses read zero
  wire logic [7:0] rdByte =
    selTcon ? tconQ :
    selAux  ? {auxQ[7:2], 2'b00} :
    selIph  ? {1'b0, iphQ[6:0]} :
    selIpl  ? {1'b0, iplQ[6:0]} :
    selIe   ? ieQ : 8'h00;

  // One-cycle ack after the request; write lands on the ack edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ackQ  <= 1'b0;
      rdatQ <= 32'h00000000;
    end else begin
      ackQ  <= access & ~ackQ;
      rdatQ <= {24'h000000, rdByte};
    end
  end
  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdatQ;

  // Control registers; top priority bit is not stored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      auxQ <= flip_pkg::RST_AUX_CTRL;
      iphQ <= flip_pkg::RST_PRIO;
      iplQ <= flip_pkg::RST_PRIO;
      ieQ  <= flip_pkg::RST_IRQ_ENABLE;
    end else if (wrStrobe) begin
      if (selAux) auxQ <= {wb_dat_i[7:2], 2'b00};
      if (selIph) iphQ <= {1'b0, wb_dat_i[6:0]}; // RULE15 RULE16
      if (selIpl) iplQ <= {1'b0, wb_dat_i[6:0]}; // RULE14 RULE16
      if (selIe)  ieQ  <= wb_dat_i[7:0];
    end
  end
  assign timer0Run = tconQ[flip_pkg::TMR0_RUN];
  assign timer1Run = tconQ[flip_pkg::TMR1_RUN];
  assign auxMode   = auxQ[flip_pkg::AUX_MODE +: 3];

  // Two-flop pin synchronisers; prev flop reads only the second stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      extMetaQ <= 2'b11;
      extSyncQ <= 2'b11;
      extPrevQ <= 2'b11;
    end else begin
      extMetaQ <= {extInputOne, extInputZero};
      extSyncQ <= extMetaQ;
      extPrevQ <= extSyncQ;
    end
  end
  wire logic [1:0] extFall = extPrevQ & ~extSyncQ;

  // Per-source raw requests in polling order
  wire logic grpSpiAdc = ((spiDoneFlag | spiWcolFlag) & auxQ[flip_pkg::SPI_EN]) | // RULE19 RULE13
                         (adcDoneFlag & auxQ[flip_pkg::ADC_EN]);
  wire logic grpPcaLv  = (pcaOvfFlag & pcaOvfEn) | (|(pcaMatchFlags & pcaMatchEn)) | // RULE20
                         (lowVoltFlag & auxQ[flip_pkg::LOWVOLT_EN]); // RULE13
  wire logic [6:0] rawReq = {grpPcaLv, grpSpiAdc, uartRxFlag | uartTxFlag, // RULE18
                             tconQ[flip_pkg::TMR1_FLAG], tconQ[flip_pkg::EXT1_FLAG],
                             tconQ[flip_pkg::TMR0_FLAG], tconQ[flip_pkg::EXT0_FLAG]}; // RULE21
  wire logic [6:0] enReq = rawReq & ieQ[6:0] & {7{ieQ[flip_pkg::GLOBAL_EN]}}; // RULE11 RULE12

  // Per-source priority level, 3 highest and 0 lowest
  logic [1:0] srcLv [flip_pkg::NUM_SRC];
  for (genvar g = 0; g < flip_pkg::NUM_SRC; g++) begin : g_lv
    assign srcLv[g] = {iphQ[g], iplQ[g]}; // RULE1
  end

  // Highest level wins; strict compare keeps the earlier source on ties
  logic       selFound;
  logic [2:0] selSrc;
  logic [1:0] selLv;
  always_comb begin
    selFound = 1'b0;
    selSrc   = 3'h0;
    selLv    = 2'h0;
    for (int i = 0; i < flip_pkg::NUM_SRC; i++) begin
      if (sampleQ[i] && (!selFound || srcLv[i] > selLv)) begin // RULE3 RULE4
        selFound = 1'b1;
        selSrc   = 3'(i);
        selLv    = srcLv[i];
      end
    end
  end

  // Highest level with a handler in progress
  logic       anyActive;
  logic [1:0] topLv;
  always_comb begin
    anyActive = 1'b0;
    topLv     = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (activeQ[i]) begin
        anyActive = 1'b1;
        topLv     = 2'(i);
      end
    end
  end

  // Blocking conditions on the polling cycle
  wire logic blockActive = anyActive && topLv >= selLv; // RULE2 RULE6
  wire logic blockInstr  = ~coreStatus.lastCycle; // RULE7
  wire logic blockAfter  = coreStatus.isReturn | coreStatus.writesIrqRegs | holdOffQ; // RULE8
  wire logic callNow = selFound & ~blockActive & ~blockInstr & ~blockAfter; // RULE5
  wire logic retDone = coreStatus.lastCycle & coreStatus.isReturn;
  wire logic [15:0] callAddr = flip_pkg::VEC_BASE + 16'(selSrc) * flip_pkg::VEC_STEP; // RULE21

  // A bus write to enable or priority holds off until the next instruction ends
  always_ff @(posedge clk) begin
    if (!reset_n) holdOffQ <= 1'b0;
    else          holdOffQ <= wrPrioEn | (holdOffQ & ~coreStatus.lastCycle); // RULE8
  end

  // Active levels: mark on call, release highest on return
  always_comb begin
    activeD = activeQ;
    if (retDone && anyActive) activeD[topLv] = 1'b0; // RULE22
    if (callNow)              activeD[selLv] = 1'b1; // RULE22
  end

  // Sample each cycle, poll the sample next cycle, register the call
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sampleQ  <= 7'h00;
      activeQ  <= 4'h0;
      vecReqQ  <= 1'b0;
      vecAddrQ <= flip_pkg::VEC_BASE;
      vecSrcQ  <= 3'h0;
      vecLvQ   <= 2'h0;
    end else begin
      sampleQ <= enReq; // RULE5
      activeQ <= activeD;
      vecReqQ <= callNow;
      if (callNow) begin
        vecAddrQ <= callAddr;
        vecSrcQ  <= selSrc;
        vecLvQ   <= selLv;
      end
    end
  end
  assign vecCall.req  = vecReqQ;
  assign vecCall.addr = vecAddrQ;

  // Timer control next value; hardware set wins over any clear
  wire logic vecE0 = callNow && selSrc == flip_pkg::SRC_EXT0;
  wire logic vecE1 = callNow && selSrc == flip_pkg::SRC_EXT1;
  wire logic vecT0 = callNow && selSrc == flip_pkg::SRC_TMR0;
  wire logic vecT1 = callNow && selSrc == flip_pkg::SRC_TMR1;
  always_comb begin
    tconD = (wrStrobe && selTcon) ? wb_dat_i[7:0] : tconQ;
    if (vecT0) tconD[flip_pkg::TMR0_FLAG] = 1'b0; // RULE17
    if (vecT1) tconD[flip_pkg::TMR1_FLAG] = 1'b0; // RULE17
    if (timer0Ovf) tconD[flip_pkg::TMR0_FLAG] = 1'b1;
    if (timer1Ovf) tconD[flip_pkg::TMR1_FLAG] = 1'b1;
    // Level mode: the pin owns the flag, hardware never clears it on entry
    if (!tconQ[flip_pkg::EXT0_TYPE]) tconD[flip_pkg::EXT0_FLAG] = ~extSyncQ[0]; // RULE9
    else begin
      if (vecE0)      tconD[flip_pkg::EXT0_FLAG] = 1'b0; // RULE10
      if (extFall[0]) tconD[flip_pkg::EXT0_FLAG] = 1'b1; // RULE9 RULE10
    end
    if (!tconQ[flip_pkg::EXT1_TYPE]) tconD[flip_pkg::EXT1_FLAG] = ~extSyncQ[1]; // RULE9
    else begin
      if (vecE1)      tconD[flip_pkg::EXT1_FLAG] = 1'b0; // RULE10
      if (extFall[1]) tconD[flip_pkg::EXT1_FLAG] = 1'b1; // RULE9 RULE10
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) tconQ <= flip_pkg::RST_TIMER_CTRL;
    else          tconQ <= tconD;
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_busReq;
    access && !ackQ;
  endsequence
  sequence s_ackPulse;
    ackQ ##1 !ackQ;
  endsequence
  a_bus_ack_pulse: assert property (s_busReq |=> s_ackPulse)
    else $error("ack not a single pulse after request");
  a_global_gate: assert property (!ieQ[flip_pkg::GLOBAL_EN] |-> ##2 !vecCall.req) // RULE11
    else $error("vector call while globally disabled");
  a_final_cycle: assert property (!coreStatus.lastCycle |=> !vecCall.req) // RULE7
    else $error("vector call outside final cycle");
  a_return_block: assert property (coreStatus.isReturn |=> !vecCall.req) // RULE8
    else $error("vector call during return instruction");
  a_level_marked: assert property (vecCall.req |-> activeQ[vecLvQ]) // RULE22
    else $error("called level not marked active");
  a_no_preempt: assert property
    (vecCall.req && $past(anyActive) |-> vecLvQ > $past(topLv)) // RULE6
    else $error("call at level not above active level");
  a_vec_address: assert property
    (vecCall.req |-> vecCall.addr == flip_pkg::VEC_BASE + 16'(vecSrcQ) * flip_pkg::VEC_STEP) // RULE21
    else $error("vector address does not match source");
  a_timer_clear: assert property
    (vecCall.req && vecSrcQ == flip_pkg::SRC_TMR0 && !$past(timer0Ovf)
     |-> !tconQ[flip_pkg::TMR0_FLAG]) // RULE17
    else $error("timer 0 flag not cleared on vectoring");
  a_edge_set: assert property
    (tconQ[flip_pkg::EXT0_TYPE] && extFall[0] |=> tconQ[flip_pkg::EXT0_FLAG]) // RULE10
    else $error("falling edge did not set flag");
  a_level_follow: assert property
    (!tconQ[flip_pkg::EXT0_TYPE] && !extSyncQ[0] |=> tconQ[flip_pkg::EXT0_FLAG]) // RULE9
    else $error("low level did not set flag");
  a_sub_enable: assert property
    (!auxQ[flip_pkg::SPI_EN] && !auxQ[flip_pkg::ADC_EN] |=> !sampleQ[5]) // RULE13
    else $error("SPI/ADC sampled while sub-enables off");
endmodule

// ==== testbench/flip_core_model.sv ====
// Behavioural core model: instruction timing, returns and vector capture
module flip_core_model #(
  parameter int INSTR_LEN = 2 // Cycles per instruction
) (
  input  wire logic                clk,        // System clock
  input  wire logic                reset_n,    // Synchronous reset, active low
  input  wire logic                retReq,     // Bench asks for a return
  input  wire flip_pkg::flip_vec_t vecCall,    // Vector call from controller
  output flip_pkg::flip_core_t     coreStatus, // Instruction status
  output int                       callCnt,    // Vector calls taken
  output logic [15:0]              callAddr    // Last vector address taken
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cyc_q;
  logic retPend_q;
  logic retRun_q;
  logic lastCyc;

  // Status is level and same-clock; a return fills one whole instruction
  assign lastCyc = (cyc_q == INSTR_LEN - 1);
  assign coreStatus.lastCycle = lastCyc;
  assign coreStatus.isReturn = retRun_q;
  assign coreStatus.writesIrqRegs = 1'b0;

  // Counts cycles and takes every call in its one-cycle window, no ack
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cyc_q <= 0;
      retPend_q <= 1'b0;
      retRun_q <= 1'b0;
      callCnt <= 0;
      callAddr <= 16'h0000;
    end else begin
      cyc_q <= lastCyc ? 0 : cyc_q + 1;
      if (lastCyc) begin
        retRun_q <= retPend_q | retReq;
        retPend_q <= 1'b0;
      end else if (retReq) begin
        retPend_q <= 1'b1;
      end
      if (vecCall.req) begin
        callCnt <= callCnt + 1;
        callAddr <= vecCall.addr;
      end
    end
  end
endmodule

// ==== testbench/flip_irq_ctrl_tb.sv ====
// Self-checking bench for the four-level interrupt controller
module flip_irq_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] A_TC = {flip_pkg::IDX_TIMER_CTRL, 2'b00};
  localparam logic [9:0] A_AX = {flip_pkg::IDX_AUX_CTRL, 2'b00};
  localparam logic [9:0] A_PH = {flip_pkg::IDX_PRIO_HIGH, 2'b00};
  localparam logic [9:0] A_PL = {flip_pkg::IDX_PRIO_LOW, 2'b00};
  localparam logic [9:0] A_IE = {flip_pkg::IDX_IRQ_ENABLE, 2'b00};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [9:0] wbAdr = 10'h000;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR;
  logic ext0 = 1'b1, ext1 = 1'b1, t0Ovf = 1'b0, t1Ovf = 1'b0, uartRx = 1'b0;
  logic uartTx = 1'b0, spiDone = 1'b0, spiWcol = 1'b0, adcDone = 1'b0;
  logic pcaOvf = 1'b0, pcaOvfEn = 1'b0, lowVolt = 1'b0, retReq = 1'b0;
  logic [3:0] pcaFlags = 4'h0, pcaEn = 4'h0;
  flip_pkg::flip_core_t coreStatus;
  flip_pkg::flip_vec_t vecCall;
  int callCnt, seenCnt = 0, error_cnt = 0, n_compared = 0;
  logic [15:0] callAddr;
  logic t0Run, t1Run;
  logic [2:0] auxM;

  // Half-period toggle gives 25 ns
  always #12.5 clk = ~clk;

  flip_irq_ctrl i_flip_irq_ctrl (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .extInputZero(ext0), .extInputOne(ext1),
    .timer0Ovf(t0Ovf), .timer1Ovf(t1Ovf), .uartRxFlag(uartRx), .uartTxFlag(uartTx),
    .spiDoneFlag(spiDone), .spiWcolFlag(spiWcol), .adcDoneFlag(adcDone), .pcaOvfFlag(pcaOvf),
    .pcaOvfEn(pcaOvfEn), .pcaMatchFlags(pcaFlags), .pcaMatchEn(pcaEn), .lowVoltFlag(lowVolt),
    .coreStatus(coreStatus), .vecCall(vecCall), .timer0Run(t0Run), .timer1Run(t1Run),
    .auxMode(auxM));

  flip_core_model i_flip_core_model (.clk(clk), .reset_n(reset_n), .retReq(retReq),
    .vecCall(vecCall), .coreStatus(coreStatus), .callCnt(callCnt), .callAddr(callAddr));

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single cycle; waits for ack under a bound, data taken at that edge
  task automatic wb(input logic we, input logic [9:0] adr, input logic [7:0] wd,
                    output logic [7:0] rd);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatW <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatR[7:0];
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] adr, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, adr, d, r);
  endtask

  task automatic rdc(input string name, input logic [9:0] adr, input logic [7:0] exp);
    logic [7:0] r;
    wb(1'b0, adr, 8'h00, r);
    chk(name, {8'h00, exp}, {8'h00, r});
  endtask

  // Counter compare avoids missing a call that lands inside a bus cycle
  task automatic expect_call(input logic [15:0] exp);
    int n;
    n = 0;
    while (callCnt == seenCnt && n < 60) begin
      @(posedge clk);
      n++;
    end
    seenCnt++;
    chk("vecAddr", exp, (callCnt >= seenCnt) ? callAddr : 16'hFFFF);
    if (n >= 60) end_sim();
  endtask

  task automatic no_call(input int n);
    repeat (n) @(posedge clk);
    chk("callCount", 16'(seenCnt), 16'(callCnt));
  endtask

  task automatic do_ret();
    @(posedge clk) retReq <= 1'b1;
    @(posedge clk) retReq <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rdc("tcReset", A_TC, 8'h00);
    rdc("ieReset", A_IE, 8'h00);
    rdc("unmapped", 10'h004, 8'h00);
    wr(A_PH, 8'h7F);
    rdc("prioHigh", A_PH, 8'h7F);
    wr(A_PL, 8'h55);
    rdc("prioLow", A_PL, 8'h55);
    wr(A_PL, 8'h00);
    wr(A_PH, 8'h00);
    // Run bits and auxiliary mode bits reach their outputs
    wr(A_TC, 8'h50);
    rdc("tcRun", A_TC, 8'h50);
    chk("timerRun", 16'h0003, {14'h0000, t1Run, t0Run});
    wr(A_AX, 8'hE3);
    rdc("auxRead", A_AX, 8'hE0);
    chk("auxMode", 16'h0007, {13'h0000, auxM});
    wr(A_AX, 8'h00);
    wr(A_TC, 8'h00);
    // Timer request held off by the global gate, then served
    wr(A_IE, 8'h02);
    @(posedge clk) t0Ovf <= 1'b1;
    @(posedge clk) t0Ovf <= 1'b0;
    no_call(20);
    rdc("tmrFlagSet", A_TC, 8'h20);
    wr(A_IE, 8'h82);
    expect_call(16'h000B);
    rdc("tmrFlagClr", A_TC, 8'h00);
    do_ret();
    // Pair 10 beats pair 01; the lower one waits for the return
    wr(A_PH, 8'h02);
    wr(A_PL, 8'h10);
    wr(A_IE, 8'h92);
    // Serial flag rises with the timer flag, so both are sampled together
    @(posedge clk) t0Ovf <= 1'b1;
    @(posedge clk) t0Ovf <= 1'b0;
    uartRx <= 1'b1;
    expect_call(16'h000B);
    no_call(20);
    do_ret();
    expect_call(16'h0023);
    no_call(20);
    @(posedge clk) uartRx <= 1'b0;
    do_ret();
    // Same level: polling order picks serial before the SPI group
    wr(A_PH, 8'h00);
    wr(A_PL, 8'h00);
    wr(A_AX, 8'h08);
    wr(A_IE, 8'hB0);
    @(posedge clk) uartTx <= 1'b1;
    spiDone <= 1'b1;
    expect_call(16'h0023);
    @(posedge clk) uartTx <= 1'b0;
    do_ret();
    expect_call(16'h002B);
    @(posedge clk) spiDone <= 1'b0;
    do_ret();
    // Low-voltage and module match share the last vector
    wr(A_AX, 8'h04);
    wr(A_IE, 8'hC0);
    @(posedge clk) lowVolt <= 1'b1;
    expect_call(16'h0033);
    @(posedge clk) lowVolt <= 1'b0;
    pcaFlags <= 4'h4;
    pcaEn <= 4'h4;
    do_ret();
    expect_call(16'h0033);
    @(posedge clk) pcaFlags <= 4'h0;
    do_ret();
    // Falling edge on input 0, flag cleared on entry
    wr(A_TC, 8'h01);
    wr(A_IE, 8'h81);
    @(posedge clk) ext0 <= 1'b0;
    expect_call(16'h0003);
    rdc("extFlagClr", A_TC, 8'h01);
    do_ret();
    no_call(10);
    // Level mode: a held-low pin asks again after each return
    wr(A_TC, 8'h00);
    expect_call(16'h0003);
    do_ret();
    expect_call(16'h0003);
    @(posedge clk) ext0 <= 1'b1;
    do_ret();
    no_call(10);
    end_sim();
  end
endmodule
